// ### pkg/rsb_pkg.sv
// constants, encodings and state types of the reset strap capture and boot select block
// assumes a single 100 MHz clock and synchronous reset strap and host port pins
package rsb_pkg;

   // ===========================================================
   // clock and timing
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int I2C_QUARTER_NS = 2500;
   // least time: round up to whole cycles
   localparam int I2C_QUARTER_CYCLES = (I2C_QUARTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ===========================================================
   // boot select encodings, other codes are reserved
   localparam logic [1:0] BOOT_SEL_HOST = 2'h0;
   localparam logic [1:0] BOOT_SEL_I2C = 2'h1;

   // ===========================================================
   // strap reset values
   localparam logic [1:0] STRAP_BOOT_RESET = 2'h0;
   localparam logic STRAP_WIDTH_RESET = 1'h0;
   localparam logic STRAP_POLARITY_RESET = 1'h0;
   localparam logic STRAP_DUAL_RESET = 1'h0;

   // ===========================================================
   // boot word layout
   localparam int BOOT_WORD_WIDTH = 64;
   localparam int HOST_WORD_WIDTH = 16;
   localparam int BYTE_WIDTH = 8;
   localparam logic [3:0] BYTES_PER_WORD = 4'h8;
   localparam logic [6:0] I2C_EPROM_ADDR = 7'h50;
   localparam int BOOT_WORDS_DEFAULT = 16;

   // ===========================================================
   // state types
   typedef enum logic [2:0] {
      BS_HOLD = 3'b000,
      BS_ROM_INIT = 3'b001,
      BS_SELECT = 3'b010,
      BS_HOST = 3'b011,
      BS_I2C = 3'b100,
      BS_DONE = 3'b101,
      BS_ERROR = 3'b110
   } rsb_boot_state_type;

   typedef enum logic [2:0] {
      IS_IDLE = 3'b000,
      IS_START = 3'b001,
      IS_ADDR = 3'b010,
      IS_ADDR_ACK = 3'b011,
      IS_READ = 3'b100,
      IS_MACK = 3'b101,
      IS_STOP = 3'b110,
      IS_END = 3'b111
   } rsb_i2c_state_type;

endpackage

// ### logic/rsb_skid_buffer.sv
// two-entry buffer with valid and ready on both sides, outputs straight from flops
// assumes one clock and a synchronous active high reset; clear empties both entries
`timescale 1ns/1ps
`default_nettype none
module rsb_skid_buffer #(
   parameter int WIDTH = 64
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic clear,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   logic [WIDTH-1:0] head_q, head_d, spare_q, spare_d;
   logic head_valid_q, head_valid_d, spare_valid_q, spare_valid_d;
   logic in_ready_q, in_ready_d;
   logic in_fire;

   // ===========================================================
   // next values
   always_comb begin
      in_fire = in_valid & in_ready_q;
      head_d = head_q;
      spare_d = spare_q;
      head_valid_d = head_valid_q;
      spare_valid_d = spare_valid_q;
      if ((out_ready & head_valid_q) | ~head_valid_q) begin
         if (spare_valid_q) begin
            head_d = spare_q;
            head_valid_d = 1'b1;
            spare_valid_d = 1'b0;
         end else if (in_fire) begin
            head_d = in_data;
            head_valid_d = 1'b1;
         end else begin
            head_valid_d = 1'b0;
         end
      end else if (in_fire) begin
         // head stalled: second word parks here so nothing is lost
         spare_d = in_data;
         spare_valid_d = 1'b1;
      end
      if (clear) begin
         head_valid_d = 1'b0;
         spare_valid_d = 1'b0;
      end
      in_ready_d = ~spare_valid_d;
   end

   // ===========================================================
   // registers
   always_ff @(posedge clock) begin
      if (srst) begin
         head_q <= '0;
         spare_q <= '0;
         head_valid_q <= 1'b0;
         spare_valid_q <= 1'b0;
         in_ready_q <= 1'b0;
      end else begin
         head_q <= head_d;
         spare_q <= spare_d;
         head_valid_q <= head_valid_d;
         spare_valid_q <= spare_valid_d;
         in_ready_q <= in_ready_d;
      end
   end

   assign in_ready = in_ready_q;
   assign out_valid = head_valid_q;
   assign out_data = head_q;
endmodule
`default_nettype wire

// ### logic/rsb_boot_select.sv
// reset strap capture, clock bypass control and boot loader source select
// assumes straps and host pins synchronous to clock; the clock is the input clock pin
`timescale 1ns/1ps
`default_nettype none
module rsb_boot_select #(
   parameter int BOOT_WORDS = rsb_pkg::BOOT_WORDS_DEFAULT,
   parameter int QUARTER_CYCLES = rsb_pkg::I2C_QUARTER_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n,
   input wire logic [1:0] boot_select_straps,
   input wire logic host_width_strap,
   input wire logic host_strobe_polarity_strap,
   input wire logic host_dual_strobe_strap,
   input wire logic rom_init_done,
   input wire logic pll_enable_req,
   output logic pll_bypass,
   output logic rom_boot_run,
   output logic boot_done,
   output logic boot_error,
   output logic [1:0] boot_select_captured,
   output logic host_width_16,
   output logic host_strobe_active_high,
   output logic host_dual_strobe,
   input wire logic [15:0] host_data,
   input wire logic host_strobe,
   input wire logic host_rw,
   output logic host_ready,
   output logic host_dma_enable,
   output logic host_irq_enable,
   output logic i2c_pin_select,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic boot_word_valid,
   output logic [63:0] boot_word_data,
   input wire logic boot_word_ready
);
   localparam logic [15:0] WORDS_TOTAL = 16'(BOOT_WORDS);
   localparam logic [15:0] LAST_BYTE = 16'(BOOT_WORDS * 8 - 1);
   localparam logic [15:0] QUARTER_LAST = 16'(QUARTER_CYCLES - 1);

   // ===========================================================
   // strap capture
   logic por_prev_q, por_prev_d;
   logic [1:0] boot_sel_q, boot_sel_d;
   logic width_q, width_d, pol_q, pol_d, dual_q, dual_d;
   logic por_rise;

   always_comb begin
      por_rise = power_on_reset_n & ~por_prev_q;
      por_prev_d = power_on_reset_n;
      boot_sel_d = boot_sel_q;
      width_d = width_q;
      pol_d = pol_q;
      dual_d = dual_q;
      // hard reset never reaches here, so its boot reuses these
      if (por_rise) begin
         boot_sel_d = boot_select_straps;
         width_d = host_width_strap;
         pol_d = host_strobe_polarity_strap;
         dual_d = host_dual_strobe_strap;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         por_prev_q <= 1'b1;
         boot_sel_q <= rsb_pkg::STRAP_BOOT_RESET;
         width_q <= rsb_pkg::STRAP_WIDTH_RESET;
         pol_q <= rsb_pkg::STRAP_POLARITY_RESET;
         dual_q <= rsb_pkg::STRAP_DUAL_RESET;
      end else begin
         // held until the next power-on release
         por_prev_q <= por_prev_d;
         boot_sel_q <= boot_sel_d;
         width_q <= width_d;
         pol_q <= pol_d;
         dual_q <= dual_d;
      end
   end

   // ===========================================================
   // boot sequence
   rsb_pkg::rsb_boot_state_type state_q, state_d;
   rsb_pkg::rsb_i2c_state_type istate_q, istate_d;
   logic hold;
   logic bypass_q, bypass_d;
   logic [15:0] words_q, words_d;
   logic i2c_err_q, i2c_err_d;
   logic pend_q, pend_d;
   logic buf_in_ready;

   always_comb begin
      hold = ~power_on_reset_n | ~hard_reset_n;
      state_d = state_q;
      bypass_d = bypass_q;
      words_d = words_q;
      if (pend_q & buf_in_ready) begin
         words_d = words_q + 16'h1;
      end
      case (state_q)
         rsb_pkg::BS_HOLD: state_d = rsb_pkg::BS_ROM_INIT;
         rsb_pkg::BS_ROM_INIT: begin
            if (rom_init_done) begin
               state_d = rsb_pkg::BS_SELECT;
            end
         end
         rsb_pkg::BS_SELECT: begin
            case (boot_sel_q)
               rsb_pkg::BOOT_SEL_HOST: state_d = rsb_pkg::BS_HOST;
               rsb_pkg::BOOT_SEL_I2C: state_d = rsb_pkg::BS_I2C;
               default: state_d = rsb_pkg::BS_ERROR;
            endcase
         end
         rsb_pkg::BS_HOST: begin
            if (words_q == WORDS_TOTAL) begin
               state_d = rsb_pkg::BS_DONE;
            end
         end
         rsb_pkg::BS_I2C: begin
            if (i2c_err_q && istate_q == rsb_pkg::IS_END) begin
               state_d = rsb_pkg::BS_ERROR;
            end else if (words_q == WORDS_TOTAL && istate_q == rsb_pkg::IS_END) begin
               state_d = rsb_pkg::BS_DONE;
            end
         end
         rsb_pkg::BS_DONE: begin
            // the pll is only switched in once the loader has finished
            if (pll_enable_req) begin
               bypass_d = 1'b0;
            end
         end
         default: state_d = state_q;
      endcase
      if (hold) begin
         state_d = rsb_pkg::BS_HOLD;
         bypass_d = 1'b1;
         words_d = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= rsb_pkg::BS_HOLD;
         bypass_q <= 1'b1;
         words_q <= '0;
      end else begin
         state_q <= state_d;
         bypass_q <= bypass_d;
         words_q <= words_d;
      end
   end

   // ===========================================================
   // host port receive, polled and without dma
   logic wr_prev_q, wr_prev_d;
   logic half_q, half_d;
   logic [7:0] low_byte_q, low_byte_d;
   logic ready_q, ready_d;
   logic strobe_on, write_on, host_take, host_word_valid;
   logic [15:0] host_word;

   always_comb begin
      strobe_on = pol_q ? host_strobe : ~host_strobe;
      // dual strobe: strobe is a write strobe; single: rw low selects write
      write_on = dual_q ? strobe_on : (strobe_on & ~host_rw);
      wr_prev_d = write_on;
      host_take = write_on & ~wr_prev_q & ready_q & (state_q == rsb_pkg::BS_HOST);
      half_d = half_q;
      low_byte_d = low_byte_q;
      host_word_valid = 1'b0;
      host_word = host_data;
      if (host_take) begin
         if (width_q) begin
            host_word_valid = 1'b1;
         end else if (!half_q) begin
            low_byte_d = host_data[7:0];
            half_d = 1'b1;
         end else begin
            // 8-bit mode pairs low byte then high byte into one word
            host_word = {host_data[7:0], low_byte_q};
            host_word_valid = 1'b1;
            half_d = 1'b0;
         end
      end
      // host must see ready before each write: status is polled
      ready_d = (state_d == rsb_pkg::BS_HOST) & ~pend_d;
      if (hold) begin
         half_d = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wr_prev_q <= 1'b0;
         half_q <= 1'b0;
         low_byte_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wr_prev_q <= wr_prev_d;
         half_q <= half_d;
         low_byte_q <= low_byte_d;
         ready_q <= ready_d;
      end
   end

   // ===========================================================
   // i2c master read of the boot eprom
   logic [15:0] div_q, div_d, bytes_q, bytes_d;
   logic [1:0] phase_q, phase_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] shift_q, shift_d;
   logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
   logic tick, go, i2c_byte_valid, last_byte;

   always_comb begin
      tick = (div_q == '0);
      last_byte = (bytes_q == LAST_BYTE);
      // a full word still waiting stretches scl low before the next byte
      go = tick & ~(istate_q == rsb_pkg::IS_READ && bit_q == 3'h0 && phase_q == 2'h0 && pend_q);
      div_d = tick ? QUARTER_LAST : div_q - 16'h1;
      istate_d = istate_q;
      phase_d = phase_q;
      bit_d = bit_q;
      shift_d = shift_q;
      bytes_d = bytes_q;
      scl_low_d = scl_low_q;
      sda_low_d = sda_low_q;
      i2c_err_d = i2c_err_q;
      i2c_byte_valid = 1'b0;
      if (istate_q == rsb_pkg::IS_IDLE) begin
         if (state_q == rsb_pkg::BS_I2C) begin
            istate_d = rsb_pkg::IS_START;
            phase_d = 2'h0;
         end
      end else if (go && istate_q != rsb_pkg::IS_END) begin
         phase_d = phase_q + 2'h1;
         case (phase_q)
            2'h0: begin
               case (istate_q)
                  rsb_pkg::IS_START: sda_low_d = 1'b0;
                  rsb_pkg::IS_ADDR: sda_low_d = ~shift_q[7];
                  rsb_pkg::IS_MACK: sda_low_d = ~last_byte;
                  rsb_pkg::IS_STOP: sda_low_d = 1'b1;
                  default: sda_low_d = 1'b0;
               endcase
            end
            2'h1: scl_low_d = 1'b0;
            2'h2: begin
               case (istate_q)
                  rsb_pkg::IS_START: sda_low_d = 1'b1;
                  rsb_pkg::IS_STOP: sda_low_d = 1'b0;
                  rsb_pkg::IS_ADDR_ACK: i2c_err_d = sda_in;
                  rsb_pkg::IS_READ: shift_d = {shift_q[6:0], sda_in};
                  default: shift_d = shift_q;
               endcase
            end
            default: begin
               scl_low_d = (istate_q != rsb_pkg::IS_STOP);
               bit_d = bit_q + 3'h1;
               case (istate_q)
                  rsb_pkg::IS_START: begin
                     istate_d = rsb_pkg::IS_ADDR;
                     shift_d = {rsb_pkg::I2C_EPROM_ADDR, 1'b1};
                     bit_d = 3'h0;
                  end
                  rsb_pkg::IS_ADDR: begin
                     shift_d = {shift_q[6:0], 1'b0};
                     if (bit_q == 3'h7) begin
                        istate_d = rsb_pkg::IS_ADDR_ACK;
                     end
                  end
                  rsb_pkg::IS_ADDR_ACK: begin
                     bit_d = 3'h0;
                     istate_d = i2c_err_q ? rsb_pkg::IS_STOP : rsb_pkg::IS_READ;
                  end
                  rsb_pkg::IS_READ: begin
                     if (bit_q == 3'h7) begin
                        istate_d = rsb_pkg::IS_MACK;
                        i2c_byte_valid = 1'b1;
                     end
                  end
                  rsb_pkg::IS_MACK: begin
                     bit_d = 3'h0;
                     bytes_d = bytes_q + 16'h1;
                     istate_d = last_byte ? rsb_pkg::IS_STOP : rsb_pkg::IS_READ;
                  end
                  default: istate_d = rsb_pkg::IS_END;
               endcase
            end
         endcase
      end
      if (hold) begin
         istate_d = rsb_pkg::IS_IDLE;
         scl_low_d = 1'b0;
         sda_low_d = 1'b0;
         i2c_err_d = 1'b0;
         bytes_d = '0;
         div_d = QUARTER_LAST;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         istate_q <= rsb_pkg::IS_IDLE;
         div_q <= '0;
         phase_q <= '0;
         bit_q <= '0;
         shift_q <= '0;
         bytes_q <= '0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         i2c_err_q <= 1'b0;
      end else begin
         istate_q <= istate_d;
         div_q <= div_d;
         phase_q <= phase_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         bytes_q <= bytes_d;
         scl_low_q <= scl_low_d;
         sda_low_q <= sda_low_d;
         i2c_err_q <= i2c_err_d;
      end
   end

   // ===========================================================
   // boot word assembly, earliest piece lands in the top bits
   logic [63:0] acc_q, acc_d;
   logic [3:0] cnt_q, cnt_d;

   always_comb begin
      acc_d = acc_q;
      cnt_d = cnt_q;
      pend_d = pend_q & ~buf_in_ready;
      if (host_word_valid) begin
         acc_d = {acc_q[47:0], host_word};
         cnt_d = cnt_q + 4'h2;
      end else if (i2c_byte_valid) begin
         acc_d = {acc_q[55:0], shift_q};
         cnt_d = cnt_q + 4'h1;
      end
      if (cnt_d == rsb_pkg::BYTES_PER_WORD) begin
         pend_d = 1'b1;
         cnt_d = '0;
      end
      if (hold) begin
         cnt_d = '0;
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         acc_q <= '0;
         cnt_q <= '0;
         pend_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         pend_q <= pend_d;
      end
   end

   rsb_skid_buffer #(
      .WIDTH(rsb_pkg::BOOT_WORD_WIDTH)
   ) u_buffer (
      .clock(clock),
      .srst(srst),
      .clear(hold),
      .in_valid(pend_q),
      .in_data(acc_q),
      .in_ready(buf_in_ready),
      .out_valid(boot_word_valid),
      .out_data(boot_word_data),
      .out_ready(boot_word_ready)
   );

   // ===========================================================
   // registered status and pin outputs
   logic run_q, done_q, err_q, pinsel_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         run_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         pinsel_q <= 1'b0;
      end else begin
         run_q <= (state_d != rsb_pkg::BS_HOLD) & (state_d != rsb_pkg::BS_DONE);
         done_q <= (state_d == rsb_pkg::BS_DONE);
         err_q <= (state_d == rsb_pkg::BS_ERROR);
         pinsel_q <= (state_d == rsb_pkg::BS_I2C);
      end
   end

   // open-drain: output value is always low, enable pulls the wire
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = ~scl_low_q;
   assign sda_oe_n = ~sda_low_q;
   assign pll_bypass = bypass_q;
   assign rom_boot_run = run_q;
   assign boot_done = done_q;
   assign boot_error = err_q;
   assign i2c_pin_select = pinsel_q;
   assign host_ready = ready_q;
   // boot always polls without dma or interrupts
   assign host_dma_enable = 1'b0;
   assign host_irq_enable = 1'b0;
   assign boot_select_captured = boot_sel_q;
   assign host_width_16 = width_q;
   assign host_strobe_active_high = pol_q;
   assign host_dual_strobe = dual_q;
endmodule
`default_nettype wire

// ### bench/rsb_eprom_model.sv
// serial boot eprom model, two-wire slave
// assumes pulled-up wire levels from the bench
`timescale 1ns/1ps
`default_nettype none
module rsb_eprom_model (
   input wire logic clock,
   input wire logic scl,
   input wire logic sda,
   output logic sda_low
);
   // ===========================================================
   // byte store and bit walker, current address read only
   logic [7:0] mem [0:63];
   logic [7:0] sh = 8'h00;
   logic scl_q = 1'h1;
   logic sda_q = 1'h1;
   logic active = 1'h0;
   logic rd = 1'h0;
   int bitn = 0;
   int idx = 0;
   initial sda_low = 1'h0;
   always @(posedge clock) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
         active <= 1'h1;
         rd <= 1'h0;
         bitn <= 0;
         sda_low <= 1'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
         active <= 1'h0;
      end else if (active && !scl_q && scl) begin
         bitn <= bitn + 1;
         // master nack ends the read, so the line is freed for the stop
         if (rd && bitn == 8 && sda) begin
            active <= 1'h0;
         end
      end else if (active && scl_q && !scl) begin
         if (bitn == 9) begin
            rd <= 1'h1;
            bitn <= 0;
            sh <= mem[idx];
            sda_low <= !mem[idx][7];
            idx <= idx + 1;
         end else if (!rd && bitn == 8) begin
            sda_low <= 1'h1;
         end else if (rd && bitn < 8) begin
            sda_low <= !sh[7-bitn];
         end else begin
            sda_low <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/rsb_boot_select_monitor.sv
// port assertions of the boot select block
// assumes one clock, srst high in reset; bound below
`timescale 1ns/1ps
`default_nettype none
module rsb_boot_select_monitor (
   input wire logic clock,
   input wire logic srst,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n,
   input wire logic [1:0] boot_select_straps,
   input wire logic host_width_strap,
   input wire logic host_strobe_polarity_strap,
   input wire logic host_dual_strobe_strap,
   input wire logic pll_enable_req,
   input wire logic pll_bypass,
   input wire logic boot_done,
   input wire logic boot_error,
   input wire logic [1:0] boot_select_captured,
   input wire logic host_width_16,
   input wire logic host_strobe_active_high,
   input wire logic host_dual_strobe,
   input wire logic host_ready,
   input wire logic host_dma_enable,
   input wire logic host_irq_enable,
   input wire logic i2c_pin_select,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic boot_word_valid,
   input wire logic [63:0] boot_word_data,
   input wire logic boot_word_ready
);
   wire logic [4:0] pins = {boot_select_straps, host_width_strap, host_strobe_polarity_strap,
                            host_dual_strobe_strap};
   wire logic [4:0] capt = {boot_select_captured, host_width_16, host_strobe_active_high,
                            host_dual_strobe};
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // ===========================================================
   // assertions
   a_strap_capture: assert property ($rose(power_on_reset_n) && !$past(srst) |=>
      capt == $past(pins)) else $error("strap capture missed");
   a_strap_stable: assert property (power_on_reset_n && $past(power_on_reset_n) &&
      $past(power_on_reset_n, 2) && !$past(srst) && !$past(srst, 2) |-> $stable(capt))
      else $error("captured straps moved");
   a_bypass_reset: assert property (!power_on_reset_n || !hard_reset_n |=> pll_bypass)
      else $error("pll not bypassed in reset");
   a_bypass_kept: assert property (pll_bypass && !pll_enable_req |=> pll_bypass)
      else $error("bypass left without request");
   a_pll_switch: assert property (pll_enable_req && boot_done && power_on_reset_n &&
      hard_reset_n |=> !pll_bypass) else $error("pll request ignored");
   a_dma_off: assert property (host_dma_enable == 1'h0)
      else $error("dma enabled");
   a_irq_off: assert property (host_irq_enable == 1'h0)
      else $error("interrupt enabled");
   a_ready_host: assert property (host_ready |->
      boot_select_captured == rsb_pkg::BOOT_SEL_HOST && !i2c_pin_select)
      else $error("host ready outside host boot");
   a_i2c_pins: assert property (!scl_oe_n || !sda_oe_n |-> i2c_pin_select &&
      boot_select_captured == rsb_pkg::BOOT_SEL_I2C) else $error("bus driven off i2c boot");
   a_open_drain: assert property (scl_out == 1'h0 && sda_out == 1'h0)
      else $error("bus driven high");
   a_error_sel: assert property (boot_error |->
      boot_select_captured != rsb_pkg::BOOT_SEL_HOST) else $error("error in host boot");
   a_word_hold: assert property (boot_word_valid && !boot_word_ready && power_on_reset_n &&
      hard_reset_n |=> boot_word_valid && $stable(boot_word_data))
      else $error("stalled word lost");
endmodule
bind rsb_boot_select rsb_boot_select_monitor mon (.*);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench of the boot select block
// assumes package, design, eprom model and monitor compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int NW = 2;
   logic clock, srst, power_on_reset_n, hard_reset_n, rom_init_done, pll_enable_req;
   logic [1:0] boot_select_straps, boot_select_captured;
   logic host_width_strap, host_strobe_polarity_strap, host_dual_strobe_strap;
   logic host_strobe, host_rw, boot_word_ready, scl_in, sda_in, sda_low, boot_word_valid;
   logic pll_bypass, rom_boot_run, boot_done, boot_error, host_width_16, host_dual_strobe;
   logic host_strobe_active_high, host_ready, host_dma_enable, host_irq_enable;
   logic i2c_pin_select, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic [15:0] host_data;
   logic [63:0] boot_word_data, w;
   logic [31:0] seed;
   logic [4:0] straps;
   int fail_count, n_compared, cycles;
   logic [63:0] exp_q[$];
   assign scl_in = scl_oe_n;
   assign {boot_select_straps, host_width_strap, host_strobe_polarity_strap,
           host_dual_strobe_strap} = straps;
   wire logic [7:0] capt = {3'h0, boot_select_captured, host_width_16,
                            host_strobe_active_high, host_dual_strobe};
   assign sda_in = sda_oe_n & !sda_low;
   rsb_boot_select #(.BOOT_WORDS(NW), .QUARTER_CYCLES(2)) dut (.*);
   rsb_eprom_model eprom (.clock(clock), .scl(scl_in), .sda(sda_in), .sda_low(sda_low));
   always #5 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp_val(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_word(input logic [63:0] e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR boot_word_data expected %h seen %h", e, g);
      end
   endtask
   task automatic wait_high(ref logic s, input int lim);
      int n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (s !== 1'h1 && n < lim);
      cmp_val("wait", 8'h1, {7'h0, s});
   endtask
   task automatic por(input logic [4:0] s);
      power_on_reset_n <= 1'h0;
      straps <= s;
      repeat (3) @(posedge clock);
      power_on_reset_n <= 1'h1;
      @(posedge clock);
      straps <= ~s;
      repeat (2) @(posedge clock);
      cmp_val("straps", {3'h0, s}, capt);
   endtask
   task automatic start_boot();
      wait_high(rom_boot_run, 20);
      @(posedge clock);
      rom_init_done <= 1'h1;
      @(posedge clock);
      rom_init_done <= 1'h0;
   endtask
   task automatic host_write(input logic [15:0] d);
      wait_high(host_ready, 400);
      @(posedge clock);
      host_data <= d;
      host_strobe <= 1'h1;
      @(posedge clock);
      host_strobe <= 1'h0;
      host_data <= ~d;
      @(posedge clock);
   endtask
   task automatic pll_pulse();
      pll_enable_req <= 1'h1;
      @(posedge clock);
      pll_enable_req <= 1'h0;
   endtask
   task automatic host_boot();
      start_boot();
      pll_pulse();
      for (int i = 0; i < NW; i++) begin
         w = {rnd(), rnd()};
         exp_q.push_back(w);
         for (int j = 7; j >= 0; j--) if (!host_width_16 || !j[0])
            host_write(16'(w >> 8 * (j ^ int'(!host_width_16))));
      end
      wait_high(boot_done, 400);
      cmp_val("pll_bypass", 8'h1, {7'h0, pll_bypass});
      pll_pulse();
      repeat (30) @(posedge clock);
      cmp_val("pll_bypass", 8'h0, {7'h0, pll_bypass});
      cmp_val("words left", 8'h0, 8'(exp_q.size()));
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ===========================================================
   // stream check, receiver stalls at random
   always @(posedge clock) boot_word_ready <= (rnd() & 32'h3) != 32'h0;
   always @(negedge clock) begin
      if ({srst, boot_word_valid, boot_word_ready} === 3'h3) begin
         cmp_word(exp_q.size() ? exp_q.pop_front() : ~boot_word_data, boot_word_data);
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ===========================================================
   // main sequence
   initial begin
      clock = 0;
      srst = 1;
      {power_on_reset_n, hard_reset_n, rom_init_done, pll_enable_req} = 4'hc;
      {straps, host_strobe, host_rw} = 7'h0;
      host_data = 16'h0000;
      seed = 32'h0000be87;
      {fail_count, n_compared, cycles} = 0;
      repeat (2) @(posedge clock);
      srst <= 1'h0;
      @(negedge clock);
      cmp_val("pll_bypass", 8'h1, {7'h0, pll_bypass});
      por(5'h06);
      host_boot();
      hard_reset_n <= 1'h0;
      repeat (3) @(posedge clock);
      hard_reset_n <= 1'h1;
      @(negedge clock);
      cmp_val("straps", 8'h06, capt);
      host_boot();
      por(5'h08);
      for (int i = 0; i < NW; i++) begin
         w = {rnd(), rnd()};
         exp_q.push_back(w);
         for (int b = 0; b < 8; b++) eprom.mem[i*8+b] = w[63-8*b -: 8];
      end
      start_boot();
      wait_high(i2c_pin_select, 20);
      wait_high(boot_done, 5000);
      repeat (30) @(posedge clock);
      cmp_val("words left", 8'h0, 8'(exp_q.size()));
      for (int c = 2; c < 4; c++) begin
         por({c[1:0], 3'h0});
         start_boot();
         wait_high(boot_error, 20);
      end
      por(5'h02);
      host_boot();
      tally_and_finish();
   end
endmodule
`default_nettype wire
